// *** logic/cisf_ahb_slave.sv ***
/*
 AHB-Lite slave front end: captures the address phase, hands writes to
 the register file in the data phase, registers read data.
 Assumes a single master, word transfers, and read data computed by the
 parent from the address-phase address.
*/
`timescale 1ns/10ps
`include "cisf_consts.svh"

module cisf_ahb_slave
(
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_hsel,
    input  wire logic [`CISF_AW-1:0]   i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic                  i_hready,
    input  wire logic [31:0]           i_hwdata,
    input  wire logic [31:0]           i_rd_data,
    output logic      [31:0]           o_hrdata,
    output logic                       o_hreadyout,
    output logic                       o_hresp,
    output logic                       o_wr_en,
    output logic      [`CISF_AW-1:0]   o_wr_addr,
    output logic      [31:0]           o_wr_data
);

    cisf_pkg::cisf_phase_e phase_q;
    cisf_pkg::cisf_phase_e phase_d;
    logic [`CISF_AW-1:0]   addr_q;
    logic [`CISF_AW-1:0]   addr_d;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic                  take;

    // address phase decode and next data phase
    always_comb
    begin
        take    = i_hsel & i_htrans[1] & i_hready;
        phase_d = cisf_pkg::ph_idle;
        addr_d  = addr_q;
        rdata_d = rdata_q;
        if (take)
        begin
            addr_d  = i_haddr;
            phase_d = i_hwrite ? cisf_pkg::ph_write : cisf_pkg::ph_read;
            if (!i_hwrite)
                rdata_d = i_rd_data;
        end
    end

    // phase, address and read data registers
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            phase_q     <= cisf_pkg::ph_idle;
            addr_q      <= '0;
            rdata_q     <= `CISF_WORD_ZERO;
            o_hreadyout <= 1'b0;
        end
        else
        begin
            phase_q     <= phase_d;
            addr_q      <= addr_d;
            rdata_q     <= rdata_d;
            o_hreadyout <= 1'b1;   // zero wait states once out of reset
        end
    end

    // write strobe in the data phase, always OKAY
    assign o_wr_en   = (phase_q == cisf_pkg::ph_write);
    assign o_wr_addr = addr_q;
    assign o_wr_data = i_hwdata;
    assign o_hrdata  = rdata_q;
    assign o_hresp   = `CISF_HRESP_OKAY;

endmodule

// *** logic/cisf_consts.svh ***
/*
 Constants of the CAN interrupt status flag block: register offsets,
 flag bit positions, counter limits and reset values.
 Assumes it is included by its bare name from the design files.
*/
`ifndef CISF_CONSTS_SVH
`define CISF_CONSTS_SVH

// register byte offsets, low address bits only
`define CISF_AW            8
`define CISF_OFF_FLAGS     8'h00
`define CISF_OFF_CLEAR     8'h04
`define CISF_OFF_ENABLE    8'h08
`define CISF_OFF_CMP2      8'h0C

// flag bit positions inside interrupt_request_flags
`define CISF_B_TXW         3
`define CISF_B_RXW         4
`define CISF_B_PASSIVE     5
`define CISF_B_BUSOFF      6
`define CISF_B_OVERLOAD    7
`define CISF_B_OVERRUN     9
`define CISF_B_MATRIX      10
`define CISF_B_CMP2        11
`define CISF_B_SLEEP       12

// bits that software clears by writing 1, and bits that exist at all
`define CISF_W1C_MASK      16'h1CF8
`define CISF_IMPL_MASK     16'h1EF8

// error counter limits, 9-bit counters
`define CISF_WARN_LIMIT    9'h060
`define CISF_PASSIVE_LIMIT 9'h080
`define CISF_BUSOFF_LIMIT  9'h100

// reset values
`define CISF_FLAGS_RST     16'h0000
`define CISF_ENABLE_RST    16'h0000
`define CISF_CMP2_RST      16'h0000
`define CISF_WORD_ZERO     32'h0000_0000
`define CISF_HRESP_OKAY    1'b0

`endif

// *** logic/cisf_pkg.sv ***
/*
 Types shared by the CAN interrupt status flag block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cisf_pkg;

    // data phase kind of the bus slave
    typedef enum logic [1:0] {
        ph_idle,
        ph_write,
        ph_read
    } cisf_phase_e;

    // one 16-bit register image
    typedef logic [15:0] cisf_half_t;

endpackage

// *** logic/cisf_top.sv ***
/*
 Interrupt status flags of a time-triggered CAN controller: error
 warning, error passive, bus-off, overload, overrun, time-trigger and
 sleep activity flags, with an enable register and one level interrupt.
 Assumes the error counters, unread status, mailbox masks, cycle timer
 and event pulses come from controller logic on the same clock.
*/
// How it works
// - transmit counter crossing 96 sets tx warning flag; write 1 clears
// - receive counter crossing 96 sets rx warning flag; write 1 clears
// - first of the two counters to cross 128 sets error passive; write 1 clears
// - transmit counter crossing 256 sets bus-off flag; write 1 clears
// - all error flags read zero after reset
// - discard or overwrite sets overrun; clears when no unmasked unread
`timescale 1ns/10ps
`include "cisf_consts.svh"

module cisf_top
#(
    parameter int CNT_W = 9,
    parameter int MB_N  = 32,
    parameter int CYC_W = 16
)
(
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_hsel,
    input  wire logic [31:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic [2:0]            i_hsize,
    input  wire logic                  i_hready,
    input  wire logic [31:0]           i_hwdata,
    output logic      [31:0]           o_hrdata,
    output logic                       o_hreadyout,
    output logic                       o_hresp,
    input  wire logic [CNT_W-1:0]      i_tx_err_count,
    input  wire logic [CNT_W-1:0]      i_rx_err_count,
    input  wire logic                  i_rx_discard,
    input  wire logic                  i_unread_overwrite,
    input  wire logic [MB_N-1:0]       i_unread_message_status,
    input  wire logic [MB_N-1:0]       i_mailbox_interrupt_mask,
    input  wire logic                  i_overload_tx,
    input  wire logic                  i_sleep_bus_activity,
    input  wire logic                  i_time_ref_done,
    input  wire logic [CYC_W-1:0]      i_cycle_time_counter,
    output logic      [15:0]           o_interrupt_request_flags,
    output logic                       o_irq
);

    // counter comparison, used for every threshold
    function automatic logic at_least(input logic [CNT_W-1:0] val,
                                      input logic [8:0]       lim);
        at_least = ({1'b0, val} >= {{CNT_W-8{1'b0}}, lim});
    endfunction

    // register image of a 16-bit value in a 32-bit word
    function automatic logic [31:0] word_of(input logic [15:0] v);
        word_of = {16'h0000, v};
    endfunction

    logic                   wr_en;
    logic [`CISF_AW-1:0]    wr_addr;
    logic [31:0]            wr_data;
    logic [31:0]            rd_data;

    cisf_pkg::cisf_half_t   flags_q;
    cisf_pkg::cisf_half_t   flags_d;
    cisf_pkg::cisf_half_t   enable_q;
    cisf_pkg::cisf_half_t   enable_d;
    logic [CYC_W-1:0]       cmp2_q;
    logic [CYC_W-1:0]       cmp2_d;
    logic                   irq_q;
    logic                   irq_d;

    logic                   txw_cond;
    logic                   rxw_cond;
    logic                   pas_cond;
    logic                   bof_cond;
    logic                   cmp_cond;
    logic [4:0]             cond_q;
    logic [4:0]             cond_d;
    logic [4:0]             rise;
    cisf_pkg::cisf_half_t   set_v;
    cisf_pkg::cisf_half_t   clr_v;
    logic                   ovr_set;
    logic                   ovr_clr;

    // bus front end
    cisf_ahb_slave u_bus
    (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_hsel      (i_hsel),
        .i_haddr     (i_haddr[`CISF_AW-1:0]),
        .i_htrans    (i_htrans),
        .i_hwrite    (i_hwrite),
        .i_hready    (i_hready),
        .i_hwdata    (i_hwdata),
        .i_rd_data   (rd_data),
        .o_hrdata    (o_hrdata),
        .o_hreadyout (o_hreadyout),
        .o_hresp     (o_hresp),
        .o_wr_en     (wr_en),
        .o_wr_addr   (wr_addr),
        .o_wr_data   (wr_data)
    );

    // threshold and compare conditions
    always_comb
    begin
        txw_cond = at_least(i_tx_err_count, `CISF_WARN_LIMIT);
        rxw_cond = at_least(i_rx_err_count, `CISF_WARN_LIMIT);
        pas_cond = at_least(i_tx_err_count, `CISF_PASSIVE_LIMIT)
                 | at_least(i_rx_err_count, `CISF_PASSIVE_LIMIT);
        bof_cond = at_least(i_tx_err_count, `CISF_BUSOFF_LIMIT);
        cmp_cond = (i_cycle_time_counter == cmp2_q);
        cond_d   = {cmp_cond, bof_cond, pas_cond, rxw_cond, txw_cond};
        rise     = cond_d & ~cond_q;   // one event per crossing
    end

    // set vector from crossings and event pulses
    always_comb
    begin
        ovr_set = i_rx_discard | i_unread_overwrite;
        set_v   = '0;
        set_v[`CISF_B_TXW]      = rise[0];
        set_v[`CISF_B_RXW]      = rise[1];
        set_v[`CISF_B_PASSIVE]  = rise[2];
        set_v[`CISF_B_BUSOFF]   = rise[3];
        set_v[`CISF_B_OVERLOAD] = i_overload_tx;
        set_v[`CISF_B_OVERRUN]  = ovr_set;
        set_v[`CISF_B_MATRIX]   = i_time_ref_done;
        set_v[`CISF_B_CMP2]     = rise[4];
        set_v[`CISF_B_SLEEP]    = i_sleep_bus_activity;
    end

    // software write-1 clears through the flags or the clear register
    always_comb
    begin
        clr_v = '0;
        if (wr_en && (wr_addr == `CISF_OFF_FLAGS ||
                      wr_addr == `CISF_OFF_CLEAR))
            clr_v = wr_data[15:0] & `CISF_W1C_MASK;
        // no unmasked unread message left
        ovr_clr = ((i_unread_message_status
                    & ~i_mailbox_interrupt_mask) == '0);
    end

    // next flag values; a set in the clearing cycle wins
    always_comb
    begin
        flags_d = ((flags_q & ~clr_v) | set_v) & `CISF_IMPL_MASK;
        flags_d[`CISF_B_OVERRUN] = ovr_set
            | (flags_q[`CISF_B_OVERRUN] & ~ovr_clr);
    end

    // enable and compare registers
    always_comb
    begin
        enable_d = enable_q;
        cmp2_d   = cmp2_q;
        if (wr_en && wr_addr == `CISF_OFF_ENABLE)
            enable_d = wr_data[15:0] & `CISF_IMPL_MASK;
        if (wr_en && wr_addr == `CISF_OFF_CMP2)
            cmp2_d = wr_data[CYC_W-1:0];
        irq_d = |(flags_d & enable_d);
    end

    // read mux from next values, so a write just before is seen
    always_comb
    begin
        case (i_haddr[`CISF_AW-1:0])
            `CISF_OFF_FLAGS:  rd_data = word_of(flags_d);
            `CISF_OFF_ENABLE: rd_data = word_of(enable_d);
            `CISF_OFF_CMP2:   rd_data = {{32-CYC_W{1'b0}}, cmp2_d};
            default:          rd_data = `CISF_WORD_ZERO;
        endcase
    end

    // state registers
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            flags_q  <= `CISF_FLAGS_RST;
            enable_q <= `CISF_ENABLE_RST;
            cmp2_q   <= `CISF_CMP2_RST;
            cond_q   <= '0;
            irq_q    <= 1'b0;
        end
        else
        begin
            flags_q  <= flags_d;
            enable_q <= enable_d;
            cmp2_q   <= cmp2_d;
            cond_q   <= cond_d;
            irq_q    <= irq_d;
        end
    end

    // outputs straight from flip-flops
    assign o_interrupt_request_flags = flags_q;
    assign o_irq                     = irq_q;

    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_txw_set: assert property (
        (txw_cond && !cond_q[0]) |=> flags_q[`CISF_B_TXW])
        else $error("tx warning flag not set on crossing 96");

    a_rxw_set: assert property (
        $rose(i_rx_err_count >= `CISF_WARN_LIMIT) |=> flags_q[`CISF_B_RXW])
        else $error("rx warning flag not set on crossing 96");

    a_passive_set: assert property (
        ((i_tx_err_count >= `CISF_PASSIVE_LIMIT ||
          i_rx_err_count >= `CISF_PASSIVE_LIMIT) && !cond_q[2])
        |=> flags_q[`CISF_B_PASSIVE])
        else $error("error passive flag not set on crossing 128");

    a_busoff_set: assert property (
        $rose(i_tx_err_count >= `CISF_BUSOFF_LIMIT)
        |=> flags_q[`CISF_B_BUSOFF])
        else $error("bus-off flag not set on crossing 256");

    a_flag_cause: assert property (
        $rose(flags_q[`CISF_B_TXW]) |-> $past(txw_cond))
        else $error("tx warning flag rose without a crossing");

    a_w1c_clear: assert property (
        (wr_en && wr_addr == `CISF_OFF_CLEAR && wr_data[`CISF_B_BUSOFF]
         && !rise[3]) |=> !flags_q[`CISF_B_BUSOFF])
        else $error("bus-off flag survived a write-1 clear");

    a_w1c_flags: assert property (
        (wr_en && wr_addr == `CISF_OFF_FLAGS && wr_data[`CISF_B_TXW]
         && !rise[0]) |=> !flags_q[`CISF_B_TXW])
        else $error("tx warning flag survived a write-1 clear");

    a_cmp2_clear: assert property (
        (wr_en && wr_addr == `CISF_OFF_CLEAR && wr_data[`CISF_B_CMP2]
         && !rise[4]) |=> !flags_q[`CISF_B_CMP2])
        else $error("compare two flag survived a write-1 clear");

    // a cleared flag stays clear while its counter stays above the limit
    a_rxw_hold: assert property (
        (!flags_q[`CISF_B_RXW] && !rise[1]) |=> !flags_q[`CISF_B_RXW])
        else $error("rx warning flag set without a crossing");

    a_passive_hold: assert property (
        (!flags_q[`CISF_B_PASSIVE] && !rise[2])
        |=> !flags_q[`CISF_B_PASSIVE])
        else $error("error passive flag set without a crossing");

    a_busoff_cause: assert property (
        $rose(flags_q[`CISF_B_BUSOFF]) |-> $past(bof_cond))
        else $error("bus-off flag rose without a crossing");

    a_ovr_set: assert property (
        (i_rx_discard || i_unread_overwrite)
        |=> flags_q[`CISF_B_OVERRUN])
        else $error("overrun flag not set by discard or overwrite");

    a_ovr_clear: assert property (
        (flags_q[`CISF_B_OVERRUN] && !ovr_set &&
         (i_unread_message_status & ~i_mailbox_interrupt_mask) == '0)
        |=> !flags_q[`CISF_B_OVERRUN])
        else $error("overrun flag not cleared when all read or masked");

    a_ovr_hold: assert property (
        (flags_q[`CISF_B_OVERRUN] &&
         (i_unread_message_status & ~i_mailbox_interrupt_mask) != '0)
        |=> flags_q[`CISF_B_OVERRUN])
        else $error("overrun flag dropped while unread unmasked");

    a_cmp2_set: assert property (
        $rose(i_cycle_time_counter == cmp2_q) |=> flags_q[`CISF_B_CMP2])
        else $error("compare two flag not set on match");

    a_overload_set: assert property (
        i_overload_tx |=> flags_q[`CISF_B_OVERLOAD])
        else $error("overload flag not set by its pulse");

    a_sleep_set: assert property (
        i_sleep_bus_activity |=> flags_q[`CISF_B_SLEEP])
        else $error("sleep activity flag not set by its pulse");

    a_matrix_set: assert property (
        i_time_ref_done |=> flags_q[`CISF_B_MATRIX])
        else $error("matrix start flag not set by its pulse");

    a_irq_level: assert property (
        o_irq == |(flags_q & enable_q))
        else $error("interrupt output disagrees with enabled flags");

    c_busoff: cover property (flags_q[`CISF_B_BUSOFF] && o_irq);
    c_ovr_cycle: cover property (
        flags_q[`CISF_B_OVERRUN] ##[1:20] !flags_q[`CISF_B_OVERRUN]);
    c_w1c: cover property (
        flags_q[`CISF_B_TXW] ##1 !flags_q[`CISF_B_TXW]);
    c_cmp2: cover property ($rose(flags_q[`CISF_B_CMP2]));
    c_sleep: cover property ($rose(flags_q[`CISF_B_SLEEP]));

endmodule

// *** test/cisf_ctrl_model.sv ***
/*
 Controller-side model: error counters, event pulses, unread status,
 mailbox masks and cycle timer that feed the flag block.
 Assumes the bench calls its tasks, which move signals after an edge.
*/
`timescale 1ns/10ps

module cisf_ctrl_model
(
    input  wire logic        i_clk,
    output logic      [8:0]  o_tx_cnt,
    output logic      [8:0]  o_rx_cnt,
    output logic      [4:0]  o_evt,
    output logic      [31:0] o_unread,
    output logic      [31:0] o_mask,
    output logic      [15:0] o_cyc
);
    // quiet controller at time zero
    initial
    begin
        o_tx_cnt = 9'h000;
        o_rx_cnt = 9'h000;
        o_evt    = 5'h00;
        o_unread = 32'h0000_0000;
        o_mask   = 32'h0000_0000;
        o_cyc    = 16'hFFFF;
    end

    // counters step at a clock edge, as real error logic does
    task automatic set_cnt(input logic [8:0] tx, input logic [8:0] rx);
        @(posedge i_clk);
        o_tx_cnt <= tx;
        o_rx_cnt <= rx;
    endtask

    // one-cycle event: 0 discard 1 overwrite 2 overload 3 sleep 4 tref
    task automatic pulse(input int idx);
        @(posedge i_clk);
        o_evt[idx] <= 1'b1;
        @(posedge i_clk);
        o_evt <= 5'h00;
    endtask

    // mailbox unread and mask levels
    task automatic set_mb(input logic [31:0] un, input logic [31:0] mk);
        @(posedge i_clk);
        o_unread <= un;
        o_mask   <= mk;
    endtask

    // cycle timer value
    task automatic set_cyc(input logic [15:0] v);
        @(posedge i_clk);
        o_cyc <= v;
    endtask
endmodule

// *** test/tb_can_interrupt_status_flags.sv ***
/*
 Self-checking bench of the CAN interrupt flag block: bus reads and
 writes, counter crossings, events, overrun auto-clear and interrupt.
 Assumes the controller model drives every controller-side input.
*/
`timescale 1ns/10ps

module tb_can_interrupt_status_flags;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hresp;
    logic [2:0]  hsize = 3'h2;
    logic        hready;
    logic [15:0] flags;
    logic        irq;
    logic [8:0]  tx_c;
    logic [8:0]  rx_c;
    logic [4:0]  evt;
    logic [31:0] unread;
    logic [31:0] mask;
    logic [15:0] cyc;
    int          checks = 0;
    int          failures = 0;
    int          cycles = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    cisf_ctrl_model PM (.i_clk(clk), .o_tx_cnt(tx_c), .o_rx_cnt(rx_c),
        .o_evt(evt), .o_unread(unread), .o_mask(mask), .o_cyc(cyc));

    cisf_top DUT (.i_clk(clk), .i_sys_rst(rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hready(hready), .i_hwdata(hwdata),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_tx_err_count(tx_c), .i_rx_err_count(rx_c),
        .i_rx_discard(evt[0]), .i_unread_overwrite(evt[1]),
        .i_unread_message_status(unread),
        .i_mailbox_interrupt_mask(mask), .i_overload_tx(evt[2]),
        .i_sleep_bus_activity(evt[3]), .i_time_ref_done(evt[4]),
        .i_cycle_time_counter(cyc), .o_interrupt_request_flags(flags),
        .o_irq(irq));

    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one single word transfer, waiting on hready in both phases
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0000_0000, x);
        chk(nm, e, x);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // flags on the port and through the bus after the set latency
    task automatic fl(input logic [15:0] e);
        repeat (2) @(posedge clk);
        #1;
        chk("flag_port", {16'h0000, e}, {16'h0000, flags});
        rdchk("flag_reg", 8'h00, {16'h0000, e});
    endtask

    task automatic t_reset;
        fl(16'h0000);
        chk("irq", 32'h0, {31'h0, irq});
        rdchk("enable", 8'h08, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_warn;
        PM.set_cnt(9'h05F, 9'h05F);
        fl(16'h0000);
        PM.set_cnt(9'h060, 9'h060);
        fl(16'h0018);
        wr(8'h00, 32'h0000_0008);
        fl(16'h0010);
        wr(8'h04, 32'h0000_0010);
        fl(16'h0000);
        PM.set_cnt(9'h000, 9'h000);
        $display("test warn done");
    endtask

    task automatic t_err;
        PM.set_cnt(9'h07F, 9'h07F);
        fl(16'h0018);
        PM.set_cnt(9'h0FF, 9'h080);
        fl(16'h0038);
        wr(8'h00, 32'h0000_1CF8);
        PM.set_cnt(9'h000, 9'h000);
        fl(16'h0000);
        PM.set_cnt(9'h080, 9'h000);
        fl(16'h0028);
        PM.set_cnt(9'h100, 9'h000);
        fl(16'h0068);
        wr(8'h04, 32'h0000_FFFF);
        fl(16'h0000);
        PM.set_cnt(9'h000, 9'h000);
        $display("test error states done");
    endtask

    task automatic t_evt;
        logic [15:0] b [3];
        b = '{16'h0080, 16'h1000, 16'h0400};
        for (int i = 0; i < 3; i++)
        begin
            PM.pulse(i + 2);
            fl(b[i]);
            wr(8'h00, {16'h0000, b[i]});
            fl(16'h0000);
        end
        wr(8'h0C, 32'h0000_0005);
        rdchk("cmp2", 8'h0C, 32'h0000_0005);
        PM.set_cyc(16'h0004);
        fl(16'h0000);
        PM.set_cyc(16'h0005);
        fl(16'h0800);
        wr(8'h04, 32'h0000_0800);
        fl(16'h0000);
        $display("test events done");
    endtask

    task automatic t_ovr;
        PM.set_mb(32'h0000_0001, 32'h0000_0000);
        PM.pulse(0);
        fl(16'h0200);
        wr(8'h00, 32'h0000_0200);
        fl(16'h0200);
        PM.set_mb(32'h0000_0001, 32'h0000_0001);
        fl(16'h0000);
        PM.set_mb(32'h0000_0002, 32'h0000_0001);
        PM.pulse(1);
        fl(16'h0200);
        PM.set_mb(32'h0000_0000, 32'h0000_0001);
        fl(16'h0000);
        $display("test overrun done");
    endtask

    task automatic t_irq;
        wr(8'h08, 32'h0000_0008);
        rdchk("enable", 8'h08, 32'h0000_0008);
        PM.set_cnt(9'h060, 9'h000);
        fl(16'h0008);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(8'h08, 32'h0000_0000);
        #1 chk("irq_masked", 32'h0, {31'h0, irq});
        wr(8'h08, 32'h0000_0008);
        #1 chk("irq_again", 32'h1, {31'h0, irq});
        wr(8'h04, 32'h0000_0008);
        #1 chk("irq_clear", 32'h0, {31'h0, irq});
        rdchk("unmapped", 8'h10, 32'h0000_0000);
        PM.set_cnt(9'h060, 9'h060);
        fl(16'h0010);
        wr(8'h08, 32'hFFFF_FFFF);
        rdchk("enable_mask", 8'h08, 32'h0000_1EF8);
        chk("irq_rx", 32'h1, {31'h0, irq});
        rdchk("clear_rd", 8'h04, 32'h0000_0000);
        PM.set_cnt(9'h000, 9'h000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        fl(16'h0000);
        chk("irq_rst", 32'h0, {31'h0, irq});
        rdchk("enable_rst", 8'h08, 32'h0000_0000);
        rdchk("cmp2_rst", 8'h0C, 32'h0000_0000);
        $display("test interrupt done");
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_warn;
        t_err;
        t_evt;
        t_ovr;
        t_irq;
        wrap_up;
    end
endmodule
